// ---- cv_bank_pkg.sv ----
package cv_bank_pkg;

	// ----------------------------------------------------------------
	// Register numbers
	// ----------------------------------------------------------------
	localparam logic [15:0] CV_SHORT_ADDR = 16'h0001;
	localparam logic [15:0] CV_MIN_SPEED  = 16'h0002;
	localparam logic [15:0] CV_START_INER = 16'h0003;
	localparam logic [15:0] CV_BRAKE_INER = 16'h0004;
	localparam logic [15:0] CV_MAX_SPEED  = 16'h0005;
	localparam logic [15:0] CV_MID_SPEED  = 16'h0006;
	localparam logic [15:0] CV_FW_VERSION = 16'h0007;
	localparam logic [15:0] CV_MAKER_ID   = 16'h0008;
	localparam logic [15:0] CV_LONG_HIGH  = 16'h0011;
	localparam logic [15:0] CV_LONG_LOW   = 16'h0012;
	localparam logic [15:0] CV_MULTI_UNIT = 16'h0013;
	localparam logic [15:0] CV_MAIN_MODE  = 16'h001d;
	localparam logic [15:0] CV_SECONDARY  = 16'h0031;
	localparam logic [15:0] CV_VAL_OFFSET = 16'h0041;
	localparam logic [15:0] CV_NUM_PAGE   = 16'h0042;

	// ----------------------------------------------------------------
	// Factory values and ranges
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_SHORT_ADDR = 8'h03;
	localparam logic [7:0] RST_MIN_SPEED  = 8'h01;
	localparam logic [7:0] RST_INERTIA    = 8'h02;
	localparam logic [7:0] RST_MAX_SPEED  = 8'h3f;
	localparam logic [7:0] RST_MID_SPEED  = 8'h1e;
	localparam logic [7:0] RST_LONG_HIGH  = 8'hc7;
	localparam logic [7:0] RST_LONG_LOW   = 8'hd0;
	localparam logic [7:0] RST_MAIN_MODE  = 8'h06;
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] SHORT_MAX      = 8'h7f;
	localparam logic [7:0] CURVE_MAX      = 8'h3f;
	localparam logic [7:0] LONG_HIGH_MIN  = 8'hc0;
	localparam logic [7:0] LONG_HIGH_MAX  = 8'he7;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_DIR_BIT    = 0;
	localparam int MODE_STEPS_BIT  = 1;
	localparam int MODE_ANALOG_BIT = 2;
	localparam int MODE_LONG_BIT   = 5;
	localparam int SEC_NOREG_BIT   = 0;
	localparam int SEC_TID_BIT     = 2;
	localparam int SEC_ABRAKE_BIT  = 7;
	localparam int MU_REV_BIT      = 7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int INERTIA_UNIT_NS  = 5000000;
	localparam int INERTIA_UNIT_CYC = INERTIA_UNIT_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] num;
		logic [7:0]  val;
	} prog_req_t;

	typedef struct packed {
		logic [13:0] addr;
		logic        is_long;
	} track_addr_t;

endpackage : cv_bank_pkg

// ---- decoder_config_variable_bank.sv ----
`timescale 1ns/10ps
// What this block does
// - Analog brake needs mode bit 2 and secondary bit 7 set.
// - Factory state: address 3, 28 steps.
// - Default: track format detected automatically.
// - Default function key to sound map.
// - Start inertia: unit equals 5 ms per step.
// - Braking inertia uses same scaling, decelerating.
// - Long address high and low byte ranges.
// - Zero multi-unit address disables consist response.
// - Multi-unit bit 7 reverses consist direction.
// - Mode bit 0 selects running direction.
// - Mode bit 1 selects 14 or 28 steps.
// - Mode bit 2 enables analog/digital switching.
// - Mode bit 5 selects short or long address.
// - Secondary bit 0 disables load regulation.
// - Secondary bit 2 enables identification transmitter.
// - Firmware version is never written by programming.
// - Legacy mode adds page times 64 to number.
// - Legacy mode adds offset times 4 to value.
// - Secondary bit 7 selects analog voltage braking.
module decoder_config_variable_bank
	import cv_bank_pkg::*;
#(
	parameter int          TICK_CYCLES = INERTIA_UNIT_CYC,
	parameter logic [7:0]  FW_VERSION  = 8'h01,
	parameter logic [7:0]  MAKER_ID    = 8'h5a  // Arbitrary value.
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Programming port
	input  wire logic        prog_wr,
	input  wire prog_req_t   prog_req,
	input  wire logic        legacy_mode,
	input  wire logic [15:0] rd_num,
	output logic      [7:0]  rd_data_q,
	// Track commands
	input  wire logic        rx_valid,
	input  wire track_addr_t rx,
	output logic             addr_hit_q,
	output logic             consist_hit_q,
	output logic             dir_rev_q,
	// Speed ramp
	input  wire logic [7:0]  target_speed,
	output logic      [7:0]  speed_q,
	// Track power and braking
	input  wire logic        analog_power,
	input  wire logic        brake_signal,
	output logic             brake_q,
	// Mode outputs
	output logic             step28_q,
	output logic             analog_auto_q,
	output logic             load_reg_en_q,
	output logic             tid_en_q,
	output logic             format_auto_q,
	// Function keys and sounds
	input  wire logic [7:0]  fkeys,
	output logic      [7:0]  sound_on_q,
	output logic             mute_q
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0]  short_q, min_q, start_q, brk_q, max_q, mid_q;
	logic [7:0]  high_q, low_q, mu_q, mode_q, sec_q, offset_q, page_q;
	logic        legacy_q;
	logic [18:0] tick_cnt_q;
	logic [5:0]  unit_cnt_q;

	// ----------------------------------------------------------------
	// Legacy translation and range check
	// ----------------------------------------------------------------
	wire logic        is_xlat  = legacy_mode && prog_req.num != CV_VAL_OFFSET
	                             && prog_req.num != CV_NUM_PAGE;
	wire logic [15:0] page_add = {2'h0, page_q, 6'h00};
	wire logic [7:0]  off_add  = {offset_q[5:0], 2'h0};
	wire logic [15:0] eff_num  = is_xlat ? prog_req.num + page_add : prog_req.num;
	wire logic [7:0]  eff_val  = is_xlat ? prog_req.val + off_add : prog_req.val;
	wire logic        curve_ok = eff_val != 8'h00 && eff_val <= CURVE_MAX;
	wire logic        sel_curve = eff_num >= CV_MIN_SPEED && eff_num <= CV_MID_SPEED;
	wire logic        leaving  = legacy_q && !legacy_mode;
	// Value range gating; high byte window.
	wire logic range_ok =
		(eff_num == CV_SHORT_ADDR) ? (eff_val != 8'h00 && eff_val <= SHORT_MAX) :
		sel_curve ? curve_ok :
		(eff_num == CV_LONG_HIGH) ? (eff_val >= LONG_HIGH_MIN && eff_val <= LONG_HIGH_MAX) :
		1'b1;
	wire logic wr_ok = prog_wr && range_ok;
	// Version and maker numbers have no write select at all.
	wire logic w_short = wr_ok && eff_num == CV_SHORT_ADDR;
	wire logic w_min   = wr_ok && eff_num == CV_MIN_SPEED;
	wire logic w_start = wr_ok && eff_num == CV_START_INER;
	wire logic w_brk   = wr_ok && eff_num == CV_BRAKE_INER;
	wire logic w_max   = wr_ok && eff_num == CV_MAX_SPEED;
	wire logic w_mid   = wr_ok && eff_num == CV_MID_SPEED;
	wire logic w_high  = wr_ok && eff_num == CV_LONG_HIGH;
	wire logic w_low   = wr_ok && eff_num == CV_LONG_LOW;
	wire logic w_mu    = wr_ok && eff_num == CV_MULTI_UNIT;
	wire logic w_mode  = wr_ok && eff_num == CV_MAIN_MODE;
	wire logic w_sec   = wr_ok && eff_num == CV_SECONDARY;
	wire logic w_off   = wr_ok && eff_num == CV_VAL_OFFSET;
	wire logic w_page  = wr_ok && eff_num == CV_NUM_PAGE;

	// Configuration registers; are left to the programmer.
	// Factory values at reset.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			short_q <= RST_SHORT_ADDR;
			min_q   <= RST_MIN_SPEED;
			start_q <= RST_INERTIA;
			brk_q   <= RST_INERTIA;
			max_q   <= RST_MAX_SPEED;
			mid_q   <= RST_MID_SPEED;
			high_q  <= RST_LONG_HIGH;
			low_q   <= RST_LONG_LOW;
			mu_q    <= RST_ZERO;
			mode_q  <= RST_MAIN_MODE;
			sec_q   <= RST_ZERO;
		end else begin
			if (w_short) short_q <= eff_val;
			if (w_min)   min_q   <= eff_val;
			if (w_start) start_q <= eff_val;
			if (w_brk)   brk_q   <= eff_val;
			if (w_max)   max_q   <= eff_val;
			if (w_mid)   mid_q   <= eff_val;
			if (w_high)  high_q  <= eff_val;
			if (w_low)   low_q   <= eff_val;
			if (w_mu)    mu_q    <= eff_val;
			if (w_mode)  mode_q  <= eff_val;
			if (w_sec)   sec_q   <= eff_val;
		end
	end

	// Page and offset; leaving legacy mode wipes them even over a write.
	// Page clears on exit; offset too.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			legacy_q <= 1'b0;
			offset_q <= RST_ZERO;
			page_q   <= RST_ZERO;
		end else begin
			legacy_q <= legacy_mode;
			if (leaving) begin
				offset_q <= RST_ZERO;
				page_q   <= RST_ZERO;
			end else begin
				if (w_off)  offset_q <= eff_val;
				if (w_page) page_q   <= eff_val;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read-back
	// ----------------------------------------------------------------
	wire logic [7:0] rd_mux =
		(rd_num == CV_SHORT_ADDR) ? short_q :
		(rd_num == CV_MIN_SPEED)  ? min_q :
		(rd_num == CV_START_INER) ? start_q :
		(rd_num == CV_BRAKE_INER) ? brk_q :
		(rd_num == CV_MAX_SPEED)  ? max_q :
		(rd_num == CV_MID_SPEED)  ? mid_q :
		(rd_num == CV_FW_VERSION) ? FW_VERSION :
		(rd_num == CV_MAKER_ID)   ? MAKER_ID :
		(rd_num == CV_LONG_HIGH)  ? high_q :
		(rd_num == CV_LONG_LOW)   ? low_q :
		(rd_num == CV_MULTI_UNIT) ? mu_q :
		(rd_num == CV_MAIN_MODE)  ? mode_q :
		(rd_num == CV_SECONDARY)  ? sec_q :
		(rd_num == CV_VAL_OFFSET) ? offset_q :
		(rd_num == CV_NUM_PAGE)   ? page_q : RST_ZERO;

	// ----------------------------------------------------------------
	// Address match and direction
	// ----------------------------------------------------------------
	wire logic        use_long = mode_q[MODE_LONG_BIT];
	wire logic [13:0] long_adr = {high_q[5:0], low_q};
	wire logic own_hit = use_long ? (rx.is_long && rx.addr == long_adr)
	                              : (!rx.is_long && rx.addr == {6'h00, short_q});
	wire logic mu_hit  = mu_q[6:0] != 7'h00 && !rx.is_long
	                     && rx.addr == {7'h00, mu_q[6:0]};
	wire logic dir_d   = mode_q[MODE_DIR_BIT] ^ (rx_valid && mu_hit && mu_q[MU_REV_BIT]);

	// Both bits gate analog braking; else only the signal.
	wire logic brake_d = brake_signal || (analog_power && mode_q[MODE_ANALOG_BIT]
	                                      && sec_q[SEC_ABRAKE_BIT]);

	// Key to sound map; keys 1..4 drive sounds 3, 2, 4, 1.
	wire logic [7:0] sound_d = {fkeys[7], 3'h0, fkeys[2], fkeys[0], fkeys[1], fkeys[3]};

	// Status outputs are registered so the track side sees clean levels.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data_q     <= RST_ZERO;
			addr_hit_q    <= 1'b0;
			consist_hit_q <= 1'b0;
			dir_rev_q     <= 1'b0;
			brake_q       <= 1'b0;
			step28_q      <= 1'b0;
			analog_auto_q <= 1'b0;
			load_reg_en_q <= 1'b0;
			tid_en_q      <= 1'b0;
			format_auto_q <= 1'b0;
			sound_on_q    <= RST_ZERO;
			mute_q        <= 1'b0;
		end else begin
			rd_data_q     <= rd_mux;
			addr_hit_q    <= rx_valid && own_hit;
			consist_hit_q <= rx_valid && mu_hit;
			dir_rev_q     <= dir_d;
			brake_q       <= brake_d;
			step28_q      <= mode_q[MODE_STEPS_BIT];   // Step count.
			analog_auto_q <= mode_q[MODE_ANALOG_BIT];  // Analog switching.
			load_reg_en_q <= !sec_q[SEC_NOREG_BIT];    // Regulation off.
			tid_en_q      <= sec_q[SEC_TID_BIT];       // Transmitter on.
			format_auto_q <= 1'b1;
			sound_on_q    <= sound_d;
			mute_q        <= fkeys[7];
		end
	end

	// ----------------------------------------------------------------
	// Inertia ramp
	// ----------------------------------------------------------------
	// A unit is one 5 ms tick; a setting of n waits n ticks per step,
	// so the ramp can lag a fast target by up to 63 units per step.
	wire logic       tick   = tick_cnt_q == 19'(TICK_CYCLES - 1);
	wire logic       accel  = target_speed > speed_q;
	wire logic       decel  = target_speed < speed_q;
	wire logic [5:0] period = accel ? start_q[5:0] : brk_q[5:0];
	// An idle ramp keeps no partial unit, but the tick counter runs free, so a new target's first unit can be short.
	wire logic       moving = accel || decel;
	wire logic       step   = tick && moving && unit_cnt_q + 6'h01 >= period;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_q <= 19'h00000;
			unit_cnt_q <= 6'h00;
			speed_q    <= RST_ZERO;
		end else begin
			tick_cnt_q <= tick ? 19'h00000 : tick_cnt_q + 19'h00001;
			if (step) begin
				unit_cnt_q <= 6'h00;
				speed_q    <= accel ? speed_q + 8'h01 : speed_q - 8'h01;
			end else if (tick && moving) begin
				unit_cnt_q <= unit_cnt_q + 6'h01;
			end else if (!moving) begin
				unit_cnt_q <= 6'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_brake_gate: assert property (@(posedge clk) disable iff (!nrst)
		(analog_power && !brake_signal && !(mode_q[2] && sec_q[7])) |=> !brake_q)
		else $error("Analog brake without both bits.");
	a_consist_off: assert property (@(posedge clk) disable iff (!nrst)
		(mu_q == 8'h00) |=> !consist_hit_q)
		else $error("Consist hit while consist inactive.");
	a_consist_dir: assert property (@(posedge clk) disable iff (!nrst)
		(rx_valid && mu_hit && mu_q[7]) |=> (dir_rev_q == !$past(mode_q[0])))
		else $error("Consist direction not reversed.");
	a_range_keep: assert property (@(posedge clk) disable iff (!nrst)
		(prog_wr && eff_num == CV_MAX_SPEED && (eff_val == 8'h00 || eff_val > 8'h3f))
		|=> $stable(max_q))
		else $error("Out-of-range write changed a register.");
	a_page_clear: assert property (@(posedge clk) disable iff (!nrst)
		$fell(legacy_mode) |=> (page_q == 8'h00 && offset_q == 8'h00))
		else $error("Page or offset kept after legacy exit.");
	a_fw_read: assert property (@(posedge clk) disable iff (!nrst)
		(rd_num == CV_FW_VERSION) |=> (rd_data_q == FW_VERSION))
		else $error("Firmware version read wrong.");
	a_speed_tick: assert property (@(posedge clk) disable iff (!nrst)
		!tick |=> $stable(speed_q))
		else $error("Speed moved between ticks.");
	a_long_hit: assert property (@(posedge clk) disable iff (!nrst)
		(rx_valid && mode_q[5] && !rx.is_long) |=> !addr_hit_q)
		else $error("Short address hit in long mode.");
	a_mute_key: assert property (@(posedge clk) disable iff (!nrst)
		fkeys[0] |=> (sound_on_q[2] && mute_q == $past(fkeys[7])))
		else $error("Key one sound map wrong.");
	a_ramp_idle: assert property (@(posedge clk) disable iff (!nrst)
		!moving |=> (unit_cnt_q == 6'h00))
		else $error("Idle ramp kept a partial unit.");
	a_abrake_on: assert property (@(posedge clk) disable iff (!nrst)
		(analog_power && mode_q[MODE_ANALOG_BIT] && sec_q[SEC_ABRAKE_BIT]) |=> brake_q)
		else $error("No brake on analog power with both bits set.");
	a_short_keep: assert property (@(posedge clk) disable iff (!nrst)
		(prog_wr && eff_num == CV_SHORT_ADDR && !range_ok) |=> $stable(short_q))
		else $error("Refused address write changed the short address.");

endmodule : decoder_config_variable_bank

// ---- command_station_model.sv ----
`timescale 1ns/10ps
// Programming side of the command station: one write strobe per request.
module command_station_model
	import cv_bank_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Programming port
	output logic      prog_wr,
	output prog_req_t prog_req
);
	initial begin
		prog_wr  = 1'b0;
		prog_req = '0;
	end

	// curve values ordered
	// Callers only send maximum above minimum and middle between the two.
	// The request lines are scrambled after the strobe so stale values never look valid.
	task automatic write(input logic [15:0] num, input logic [7:0] val);
		@(posedge clk);
		#1 prog_wr = 1'b1;
		prog_req = '{num: num, val: val};
		@(posedge clk);
		#1 prog_wr = 1'b0;
		prog_req = ~prog_req;
	endtask : write
endmodule : command_station_model

// ---- tb_decoder_config_variable_bank.sv ----
`timescale 1ns/10ps
module tb_decoder_config_variable_bank;
	import cv_bank_pkg::*;
	localparam int         T  = 4;
	localparam logic [7:0] FW = 8'h21;
	localparam logic [7:0] MK = 8'h3c;  // Arbitrary value.
	logic clk, nrst, prog_wr, legacy_mode, rx_valid, analog_power, brake_signal;
	logic addr_hit_q, consist_hit_q, dir_rev_q, brake_q, mute_q;
	logic step28_q, analog_auto_q, load_reg_en_q, tid_en_q, format_auto_q;
	logic [15:0] rd_num;
	logic [7:0]  rd_data_q, target_speed, speed_q, fkeys, sound_on_q, v, s;
	prog_req_t   prog_req;
	track_addr_t rx;
	int          seed, bad_count, checked;

	command_station_model i_command_station_model (.clk(clk), .prog_wr(prog_wr),
		.prog_req(prog_req));
	decoder_config_variable_bank #(.TICK_CYCLES(T), .FW_VERSION(FW), .MAKER_ID(MK))
	i_decoder_config_variable_bank (.clk(clk), .nrst(nrst), .prog_wr(prog_wr),
		.prog_req(prog_req), .legacy_mode(legacy_mode), .rd_num(rd_num),
		.rd_data_q(rd_data_q), .rx_valid(rx_valid), .rx(rx), .addr_hit_q(addr_hit_q),
		.consist_hit_q(consist_hit_q), .dir_rev_q(dir_rev_q), .target_speed(target_speed),
		.speed_q(speed_q), .analog_power(analog_power), .brake_signal(brake_signal),
		.brake_q(brake_q), .step28_q(step28_q), .analog_auto_q(analog_auto_q),
		.load_reg_en_q(load_reg_en_q), .tid_en_q(tid_en_q), .format_auto_q(format_auto_q),
		.fkeys(fkeys), .sound_on_q(sound_on_q), .mute_q(mute_q));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Expected sounds: f1->3, f2->2, f3->4, f4->1, f8->8.
	function automatic logic [7:0] exp_sound(input logic [7:0] k);
		logic [7:0] e;
		e    = 8'h00;
		e[2] = k[0];  // Key one drives sound three.
		e[1] = k[1];
		e[3] = k[2];
		e[0] = k[3];
		e[7] = k[7];  // Key eight drives the muting sound.
		return e;
	endfunction : exp_sound

	task automatic end_of_test();
		if (bad_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk

	task automatic wr(input logic [15:0] n, input logic [7:0] d);
		i_command_station_model.write(n, d);
	endtask : wr

	task automatic rd(input logic [15:0] n, input logic [7:0] e);
		@(posedge clk);
		#1 rd_num = n;
		@(posedge clk);
		#1 chk(rd_data_q, e);
	endtask : rd

	// Returns {own hit, consist hit, reversed seen in the next two cycles}.
	task automatic track(input logic [13:0] a, input logic lg, output logic [7:0] r);
		@(posedge clk);
		#1 rx_valid = 1'b1;
		rx = '{addr: a, is_long: lg};
		@(posedge clk);
		#1 rx_valid = 1'b0;
		rx = ~rx;
		r = {5'h0, addr_hit_q, consist_hit_q, dir_rev_q};
		@(posedge clk);
		#1 r[0] = r[0] | dir_rev_q;
	endtask : track

	task automatic ramp(input logic [7:0] tgt, input int n);
		int c;
		int st;
		st = (tgt > speed_q) ? tgt - speed_q : speed_q - tgt;
		c = 0;
		target_speed = tgt;
		while (speed_q !== tgt && c < 2000) begin
			@(posedge clk);
			#1 c++;
		end
		if (c >= 2000) begin
			bad_count++;
			end_of_test();
		end else begin
			chk(8'(c > (st * n - 1) * T && c <= st * n * T), 8'h01);
		end
	endtask : ramp

	// ------------------------------------------------------------
	// Clock and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		logic [15:0] nums [14];
		logic [7:0]  exps [14];
		logic [7:0]  r;
		nums = '{1, 2, 3, 4, 5, 6, 7, 8, 16'h11, 16'h12, 16'h13, 16'h1d, 16'h31, 16'h20};
		exps = '{3, 1, 2, 2, 8'h3f, 8'h1e, FW, MK, 8'hc7, 8'hd0, 0, 6, 0, 0};
		seed = 32'h2133;
		{bad_count, checked} = '0;
		{nrst, legacy_mode, rx_valid, analog_power, brake_signal} = '0;
		{rd_num, target_speed, fkeys} = '0;
		rx = '0;
		repeat (8) @(posedge clk);
		#1 nrst = 1'b1;
		@(posedge clk);
		#1 chk({3'h0, step28_q, analog_auto_q, load_reg_en_q, tid_en_q, format_auto_q}, 8'h1d);
		for (int i = 0; i < 14; i++) rd(nums[i], exps[i]);
		track(14'd3, 1'b0, r);
		chk(r, 8'h04);
		// Refused values, read-only places, then in-range writes.
		wr(3, 0);
		wr(4, 8'h40);
		wr(16'h11, 8'hbf);
		wr(16'h11, 8'he8);
		wr(7, 8'h5b);
		wr(1, 8'h80);
		for (int i = 0; i < 7; i++) rd(nums[i], exps[i]);
		rd(16'h11, 8'hc7);
		wr(5, 8'h28);
		wr(16'h11, 8'he7);
		rd(5, 8'h28);
		rd(16'h11, 8'he7);
		for (int k = 0; k < 9; k++) begin
			@(posedge clk);
			#1 fkeys = (k < 8) ? 8'h01 << k : 8'($random(seed));
			@(posedge clk);
			#1 chk(sound_on_q, exp_sound(fkeys));
			chk({7'h0, mute_q}, {7'h0, fkeys[7]});
		end
		analog_power = 1'b1;
		for (int k = 0; k < 10; k++) begin
			v = (k == 0) ? 8'h06 : (k == 1) ? 8'h01 : 8'($random(seed)) & 8'hdf;
			s = (k == 0) ? 8'h84 : (k == 1) ? 8'h80 : 8'($random(seed));
			brake_signal = s[3];
			wr(16'h1d, v);
			wr(16'h31, s);
			repeat (2) @(posedge clk);
			#1 chk({5'h0, dir_rev_q, step28_q, analog_auto_q}, {5'h0, v[0], v[1], v[2]});
			r = {5'h0, !s[0], s[2], s[3] | (v[2] & s[7])};
			chk({5'h0, load_reg_en_q, tid_en_q, brake_q}, r);
		end
		{analog_power, brake_signal} = 2'b00;
		v = 8'($random(seed));
		wr(16'h1d, 8'h20);
		wr(16'h11, 8'hc5);
		wr(16'h12, v);
		track({6'h05, v}, 1'b1, r);
		chk(r, 8'h04);
		track(14'd3, 1'b0, r);
		chk(r, 8'h00);
		wr(16'h1d, 8'h00);
		track(14'h0a, 1'b0, r);
		chk(r, 8'h00);
		wr(16'h13, 8'h8a);
		track(14'h0a, 1'b0, r);
		chk(r, 8'h03);
		// Legacy programming: offset then page, both cleared on leaving.
		legacy_mode = 1'b1;
		wr(16'h41, 8'd25);
		wr(16'h31, 8'd57);
		rd(16'h31, 8'd157);
		wr(16'h42, 8'd1);
		wr(16'h12, 8'h07);
		rd(16'h12, v);
		@(posedge clk);
		#1 legacy_mode = 1'b0;
		@(posedge clk);
		#1 legacy_mode = 1'b1;
		wr(16'h12, 8'h07);
		rd(16'h12, 8'h07);
		legacy_mode = 1'b0;
		// A reset in mid-run must bring the factory values back.
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		@(posedge clk);
		#1 chk({3'h0, step28_q, analog_auto_q, load_reg_en_q, tid_en_q, format_auto_q}, 8'h1d);
		rd(16'h13, 8'h00);
		rd(16'h1d, 8'h06);
		wr(3, 2);
		wr(4, 3);
		ramp(8'd6, 2);
		ramp(8'd1, 3);
		end_of_test();
	end
endmodule : tb_decoder_config_variable_bank
